// ===== rtl/stby_pkg.sv
`default_nettype none
package stby_pkg;
  // Standby state codes, one-hot
  typedef enum logic [3:0] {
    ST_SLEEP = 4'h1,
    ST_TIMER = 4'h2,
    ST_RTC   = 4'h4,
    ST_STOP  = 4'h8
  } stby_state_t;

  // Running clock mode codes
  localparam logic [2:0] MODE_HSRC = 3'h0;
  localparam logic [2:0] MODE_MAIN = 3'h1;
  localparam logic [2:0] MODE_PLL  = 3'h2;
  localparam logic [2:0] MODE_LSRC = 3'h4;
  localparam logic [2:0] MODE_SUB  = 3'h5;

  // Wake source bit positions (status and mask share this layout)
  localparam int SRC_NMI    = 0;
  localparam int SRC_EXT    = 1;
  localparam int SRC_HWWDG  = 2;
  localparam int SRC_USBWK  = 3;
  localparam int SRC_WATCH  = 4;
  localparam int SRC_RTC    = 5;
  localparam int SRC_CECRX  = 6;
  localparam int SRC_REMRX  = 7;
  localparam int SRC_LVD    = 8;
  localparam int SRC_CECTX  = 9;
  localparam int SRC_PERIPH = 10;
  localparam int NSRC = 11;

  // Reset source positions
  localparam int RST_PIN   = 0;
  localparam int RST_LV    = 1;
  localparam int RST_SWWDG = 2;
  localparam int RST_HWWDG = 3;
  localparam int RST_CSV   = 4;
  localparam int RST_FREQ  = 5;
  localparam int NRST = 6;

  // Register map
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MASK   = 4'h2;
  localparam logic [3:0] ADDR_CLKS   = 4'h3;
  localparam logic [NSRC-1:0] MASK_RESET = 11'h000;

  typedef struct packed {
    logic main_osc_enable;
    logic sub_osc_enable;
    logic main_pll_enable;
    logic pll_input_clock_select;
    logic usb_pll_enable;
    logic apb1_clock_enable;
    logic apb2_clock_enable;
  } clock_mode_control_t;

  // Clock run enables
  typedef struct packed {
    logic hsrc;
    logic main_osc;
    logic main_pll;
    logic lsrc;
    logic sub_osc;
    logic usb_pll;
    logic cpu;
    logic ahb;
    logic apb0;
    logic apb1;
    logic apb2;
  } clk_run_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage
`default_nettype wire

// ===== rtl/stby_clk_wake.sv
`default_nettype none
// How it works
// RULE1 - In timer states CPU, AHB, APB and USB PLL stop, low RC runs, high RC runs only in high RC, main and PLL variants.
// RULE2 - In the high RC timer variant main osc follows its enable and the PLL needs both enables.
// RULE3 - Main timer keeps main osc and gates the PLL by its enable; PLL timer keeps the PLL and gates main osc by enable and input select.
// RULE4 - The sub oscillator always runs in sub timer and follows its enable otherwise.
// RULE5 - RTC standby keeps only the sub oscillator; stop halts everything.
// RULE6 - Each state accepts only its own set of reset sources.
// RULE7 - Sleep wakes on any enabled interrupt except the control-link transmit one; timer wakes on a fixed list.
// RULE8 - RTC and stop states wake on their own shorter lists.
// RULE9 - A control-link transmit interrupt never wakes any standby state.
// RULE10 - A reset wake resumes in high RC run mode after both RC oscillators settle.
// RULE11 - Wake is the OR of permitted sources; all others are masked.
module stby_clk_wake (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire stby_pkg::reg_req_t req_i,
  output logic [15:0] rdata_o,
  // Standby control
  input wire logic stby_enter_i,
  input wire stby_pkg::stby_state_t stby_state_i,
  input wire logic [2:0] running_clock_mode_i,
  input wire logic hsrc_ready_i,
  input wire logic lsrc_ready_i,
  // Wake sources, asynchronous
  input wire logic [stby_pkg::NSRC-1:0] irq_src_i,
  input wire logic [stby_pkg::NRST-1:0] rst_src_i,
  // Outputs
  output stby_pkg::clk_run_t clk_run_o,
  output logic wake_o,
  output logic resume_hsrc_o,
  output logic [2:0] resume_mode_o,
  output logic irq_o
);
  import stby_pkg::*;

  typedef struct packed {
    clock_mode_control_t ctl;
    logic [NSRC-1:0] status;
    logic [NSRC-1:0] mask;
    logic in_stby;
    stby_state_t st;
    logic [2:0] mode;
    logic rst_wait;
    logic [NSRC-1:0] s1, s2, s3, irq_q;
    logic [NRST-1:0] r1, r2, r3, rst_q;
    clk_run_t run;
    logic wake;
    logic resume_hsrc;
    logic [2:0] resume_mode;
    logic irq;
    logic [15:0] rdata;
  } state_t;

  state_t state_reg, state_next;
  logic [NSRC-1:0] irq_ok;
  logic [NRST-1:0] rst_ok;
  logic irq_wake, rst_wake;
  clk_run_t run_c;

  always_comb begin
    clock_mode_control_t c;
    logic var_mh;
    c = state_reg.ctl;
    var_mh = (state_reg.mode == MODE_HSRC) || (state_reg.mode == MODE_MAIN)
      || (state_reg.mode == MODE_PLL);
    run_c = '1;
    if (state_reg.in_stby) begin
      unique case (state_reg.st)
        ST_SLEEP: begin
          run_c.cpu = 1'b0;
          run_c.apb1 = c.apb1_clock_enable;
          run_c.apb2 = c.apb2_clock_enable;
          run_c.hsrc = var_mh;
          run_c.lsrc = 1'b1;
          run_c.main_osc = 1'b0;
          run_c.main_pll = 1'b0;
          run_c.usb_pll = 1'b0;
          if (state_reg.mode == MODE_HSRC) begin
            run_c.main_osc = c.main_osc_enable;
            run_c.main_pll = c.main_osc_enable & c.main_pll_enable;
            run_c.usb_pll = c.main_osc_enable & c.usb_pll_enable;
          end else if (state_reg.mode == MODE_MAIN) begin
            run_c.main_osc = 1'b1;
            run_c.main_pll = c.main_pll_enable;
            run_c.usb_pll = c.usb_pll_enable;
          end else if (state_reg.mode == MODE_PLL) begin
            run_c.main_osc = c.main_osc_enable & c.pll_input_clock_select;
            run_c.main_pll = 1'b1;
            run_c.usb_pll = c.usb_pll_enable;
          end
          run_c.sub_osc = (state_reg.mode == MODE_SUB) | c.sub_osc_enable;
        end
        ST_TIMER: begin
          run_c.cpu = 1'b0; // [RULE1]
          run_c.ahb = 1'b0; // [RULE1]
          run_c.apb0 = 1'b0; // [RULE1]
          run_c.apb1 = 1'b0; // [RULE1]
          run_c.apb2 = 1'b0; // [RULE1]
          run_c.usb_pll = 1'b0; // [RULE1]
          run_c.lsrc = 1'b1; // [RULE1]
          run_c.hsrc = var_mh; // [RULE1]
          run_c.main_osc = 1'b0;
          run_c.main_pll = 1'b0;
          if (state_reg.mode == MODE_HSRC) begin
            run_c.main_osc = c.main_osc_enable; // [RULE2]
            run_c.main_pll = c.main_osc_enable & c.main_pll_enable; // [RULE2]
          end else if (state_reg.mode == MODE_MAIN) begin
            run_c.main_osc = 1'b1; // [RULE3]
            run_c.main_pll = c.main_pll_enable; // [RULE3]
          end else if (state_reg.mode == MODE_PLL) begin
            run_c.main_pll = 1'b1; // [RULE3]
            run_c.main_osc = c.main_osc_enable & c.pll_input_clock_select;
          end
          run_c.sub_osc = (state_reg.mode == MODE_SUB)
            | c.sub_osc_enable; // [RULE4]
        end
        ST_RTC: begin
          run_c = '0;
          run_c.sub_osc = 1'b1; // [RULE5]
        end
        ST_STOP: begin
          run_c = '0; // [RULE5]
        end
        default: run_c = '1;
      endcase
    end
  end

  // Per-state permitted source sets
  always_comb begin
    irq_ok = '0;
    rst_ok = '0;
    unique case (state_reg.st)
      ST_SLEEP: begin
        irq_ok = ~state_reg.mask; // [RULE7]
        rst_ok = '1; // [RULE6]
      end
      ST_TIMER: begin
        irq_ok[SRC_NMI] = 1'b1; // [RULE7]
        irq_ok[SRC_EXT] = 1'b1;
        irq_ok[SRC_HWWDG] = 1'b1;
        irq_ok[SRC_USBWK] = 1'b1;
        irq_ok[SRC_WATCH] = 1'b1;
        irq_ok[SRC_RTC] = 1'b1;
        irq_ok[SRC_CECRX] = 1'b1;
        irq_ok[SRC_REMRX] = 1'b1;
        irq_ok[SRC_LVD] = 1'b1;
        rst_ok = '1; // [RULE6]
        rst_ok[RST_SWWDG] = 1'b0;
        rst_ok[RST_FREQ] = (state_reg.mode == MODE_MAIN)
          || (state_reg.mode == MODE_PLL);
      end
      ST_RTC: begin
        irq_ok[SRC_NMI] = 1'b1; // [RULE8]
        irq_ok[SRC_EXT] = 1'b1;
        irq_ok[SRC_USBWK] = 1'b1;
        irq_ok[SRC_RTC] = 1'b1;
        irq_ok[SRC_CECRX] = 1'b1;
        irq_ok[SRC_REMRX] = 1'b1;
        irq_ok[SRC_LVD] = 1'b1;
        rst_ok[RST_PIN] = 1'b1; // [RULE6]
        rst_ok[RST_LV] = 1'b1;
      end
      ST_STOP: begin
        irq_ok[SRC_NMI] = 1'b1; // [RULE8]
        irq_ok[SRC_EXT] = 1'b1;
        irq_ok[SRC_USBWK] = 1'b1;
        irq_ok[SRC_LVD] = 1'b1;
        rst_ok[RST_PIN] = 1'b1; // [RULE6]
        rst_ok[RST_LV] = 1'b1;
      end
      default: begin
        irq_ok = '0;
        rst_ok = '0;
      end
    endcase
    irq_ok[SRC_CECTX] = 1'b0; // [RULE9]
  end

  // Gating before OR keeps a forbidden source from ever waking
  assign irq_wake = |(state_reg.irq_q & irq_ok); // [RULE11]
  assign rst_wake = |(state_reg.rst_q & rst_ok); // [RULE11]

  always_comb begin
    logic [NSRC-1:0] clr;
    state_next = state_reg;
    clr = '0;
    state_next.s1 = irq_src_i;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    if (state_reg.s2 == state_reg.s3) begin
      state_next.irq_q = state_reg.s3;
    end
    state_next.r1 = rst_src_i;
    state_next.r2 = state_reg.r1;
    state_next.r3 = state_reg.r2;
    if (state_reg.r2 == state_reg.r3) begin
      state_next.rst_q = state_reg.r3;
    end
    if (req_i.wr) begin
      unique case (req_i.addr)
        ADDR_CTRL: state_next.ctl = req_i.wdata[6:0];
        ADDR_STATUS: clr = req_i.wdata[NSRC-1:0];
        ADDR_MASK: state_next.mask = req_i.wdata[NSRC-1:0];
        default: ;
      endcase
    end
    // Set beats clear
    state_next.status = (state_reg.status & ~clr) | state_reg.irq_q;
    state_next.rdata = '0;
    if (req_i.rd) begin
      unique case (req_i.addr)
        ADDR_CTRL: state_next.rdata = {9'h000, state_reg.ctl};
        ADDR_STATUS: state_next.rdata = {5'h00, state_reg.status};
        ADDR_MASK: state_next.rdata = {5'h00, state_reg.mask};
        ADDR_CLKS: state_next.rdata = {5'h00, state_reg.run};
        default: state_next.rdata = '0;
      endcase
    end
    state_next.wake = 1'b0;
    if (!state_reg.in_stby) begin
      if (stby_enter_i) begin
        state_next.in_stby = 1'b1;
        state_next.st = stby_state_i;
        state_next.mode = running_clock_mode_i;
      end
    end else if (rst_wake) begin
      state_next.in_stby = 1'b0;
      state_next.wake = 1'b1;
      state_next.rst_wait = 1'b1; // [RULE10]
    end else if (irq_wake) begin
      state_next.in_stby = 1'b0;
      state_next.wake = 1'b1;
      state_next.resume_mode = state_reg.mode;
    end
    if (state_reg.rst_wait && hsrc_ready_i && lsrc_ready_i) begin
      state_next.rst_wait = 1'b0;
      state_next.resume_hsrc = 1'b1; // [RULE10]
      state_next.resume_mode = MODE_HSRC; // [RULE10]
    end else begin
      state_next.resume_hsrc = 1'b0;
    end
    state_next.run = run_c;
    state_next.irq = |(state_reg.status & ~state_reg.mask);
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= '0;
      state_reg.st <= ST_SLEEP;
      state_reg.mask <= MASK_RESET;
      state_reg.run <= '1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign clk_run_o = state_reg.run;
  assign wake_o = state_reg.wake;
  assign resume_hsrc_o = state_reg.resume_hsrc;
  assign resume_mode_o = state_reg.resume_mode;
  assign irq_o = state_reg.irq;
  assign rdata_o = state_reg.rdata;

  property p_stop_all;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (state_reg.in_stby && state_reg.st == ST_STOP) |=> clk_run_o == '0;
  endproperty
  a_stop_all: assert property (p_stop_all) else $error("stop clocks"); // RULE5

  property p_timer_bus;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (state_reg.in_stby && state_reg.st == ST_TIMER)
      |=> !clk_run_o.cpu && !clk_run_o.ahb && !clk_run_o.usb_pll
      && clk_run_o.lsrc;
  endproperty
  a_timer_bus: assert property (p_timer_bus) else $error("timer clk"); // RULE1

  property p_cectx;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (state_reg.in_stby && state_reg.st != ST_SLEEP
      && state_reg.irq_q == (NSRC'(1) << SRC_CECTX) && !rst_wake)
      |=> !wake_o;
  endproperty
  a_cectx: assert property (p_cectx) else $error("tx woke"); // RULE9

  // Low-speed variants have no use for the fast oscillators or the PLL
  property p_timer_slow;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (state_reg.in_stby && state_reg.st == ST_TIMER
      && (state_reg.mode == MODE_LSRC || state_reg.mode == MODE_SUB))
      |=> !clk_run_o.hsrc && !clk_run_o.main_osc && !clk_run_o.main_pll;
  endproperty
  a_timer_slow: assert property (p_timer_slow) else $error("slow tmr"); // RULE1

  property p_sub_timer;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (state_reg.in_stby && state_reg.st == ST_TIMER
      && state_reg.mode == MODE_SUB) |=> clk_run_o.sub_osc;
  endproperty
  a_sub_timer: assert property (p_sub_timer) else $error("sub tmr"); // RULE4

  property p_rtc_sub;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (state_reg.in_stby && state_reg.st == ST_RTC)
      |=> clk_run_o == 11'h040;
  endproperty
  a_rtc_sub: assert property (p_rtc_sub) else $error("rtc clocks"); // RULE5

  // A software watchdog reset alone must leave the timer state asleep
  property p_swwdg;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    (state_reg.in_stby && state_reg.st == ST_TIMER
      && state_reg.rst_q == (NRST'(1) << RST_SWWDG) && !irq_wake)
      |=> !wake_o;
  endproperty
  a_swwdg: assert property (p_swwdg) else $error("swwdg woke"); // RULE6

  sequence s_rst_ready;
    state_reg.rst_wait && hsrc_ready_i && lsrc_ready_i;
  endsequence

  sequence s_resumed;
    resume_hsrc_o && resume_mode_o == MODE_HSRC;
  endsequence

  property p_resume;
    @(posedge core_clk_i) disable iff (!arst_n_i)
    s_rst_ready |=> s_resumed;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume"); // RULE10
endmodule
`default_nettype wire

// ===== tb/test_stby_clk_wake.sv
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("FAIL at %0t: got %h expected %h", $time, g, e); end end
module test_stby_clk_wake;
  import stby_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [3:0] a; logic [15:0] d;} note_t;
  logic core_clk_i = 0, arst_n_i = 0, stby_enter_i = 0;
  logic hsrc_ready_i = 1, lsrc_ready_i = 1;
  reg_req_t req_i = '0;
  stby_state_t stby_state_i = ST_SLEEP;
  logic [2:0] running_clock_mode_i = MODE_HSRC, mode, resume_mode_o;
  logic [NSRC-1:0] irq_src_i = '0;
  logic [NRST-1:0] rst_src_i = '0;
  logic [15:0] rdata_o;
  clk_run_t clk_run_o;
  logic wake_o, resume_hsrc_o, irq_o, rd_q = 0;
  logic [2:0] modes [5] = '{MODE_HSRC, MODE_MAIN, MODE_PLL, MODE_LSRC,
    MODE_SUB};
  int fails = 0, n_compared = 0, res_seen = 0;
  note_t rq [$];
  bit wq [$];
  stby_clk_wake dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .req_i(req_i), .rdata_o(rdata_o), .stby_enter_i(stby_enter_i),
    .stby_state_i(stby_state_i),
    .running_clock_mode_i(running_clock_mode_i),
    .hsrc_ready_i(hsrc_ready_i), .lsrc_ready_i(lsrc_ready_i),
    .irq_src_i(irq_src_i), .rst_src_i(rst_src_i), .clk_run_o(clk_run_o),
    .wake_o(wake_o), .resume_hsrc_o(resume_hsrc_o),
    .resume_mode_o(resume_mode_o), .irq_o(irq_o));
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  // Monitor: each result on the ports consumes the oldest note
  always @(posedge core_clk_i) begin
    note_t n;
    if (rd_q && rq.size() > 0) begin
      n = rq.pop_front();
      `CHK(rdata_o, n.d)
      if (n.a == ADDR_CLKS) begin
        `CHK(clk_run_o, n.d[10:0])
      end
    end
    if (wake_o === 1'b1) begin
      `CHK(32'(wq.size()) > 0, 1'b1)
      if (wq.size() > 0) void'(wq.pop_front());
    end
    if (resume_hsrc_o === 1'b1) res_seen++;
    rd_q <= req_i.rd;
  end
  task automatic wrap_up;
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // Bus cycle followed by an idle cycle, so strobes never merge
  task automatic bus(logic [3:0] a, logic [15:0] d, bit w);
    if (!w) rq.push_back('{a, d});
    req_i <= '{addr: a, wdata: w ? d : 16'h0000, wr: w, rd: !w};
    @(posedge core_clk_i);
    req_i <= '0;
    @(posedge core_clk_i);
  endtask
  task automatic enter(stby_state_t s, logic [2:0] m);
    mode = m;
    stby_state_i <= s;
    running_clock_mode_i <= m;
    stby_enter_i <= 1'b1;
    @(posedge core_clk_i);
    stby_enter_i <= 1'b0;
    step(3);
  endtask
  function automatic bit allowed(stby_state_t s, logic [2:0] m, bit r,
      int b);
    logic [10:0] im;
    logic [5:0] rm;
    case (s)
      ST_SLEEP: begin im = 11'h5ff; rm = 6'h3f; end
      ST_TIMER: begin
        im = 11'h1ff;
        rm = (m == MODE_MAIN || m == MODE_PLL) ? 6'h3b : 6'h1b;
      end
      ST_RTC: begin im = 11'h1eb; rm = 6'h03; end
      default: begin im = 11'h10b; rm = 6'h03; end
    endcase
    return r ? rm[b] : im[b];
  endfunction
  function automatic logic [10:0] exp_clk(stby_state_t s, logic [2:0] m,
      clock_mode_control_t c);
    logic hs, mo, pl;
    if (s == ST_RTC) return 11'h040;
    if (s == ST_STOP) return 11'h000;
    hs = m inside {MODE_HSRC, MODE_MAIN, MODE_PLL};
    mo = (m == MODE_MAIN) || (m == MODE_HSRC && c.main_osc_enable) ||
      (m == MODE_PLL && c.main_osc_enable && c.pll_input_clock_select);
    pl = (m == MODE_PLL) || (m == MODE_MAIN && c.main_pll_enable) ||
      (m == MODE_HSRC && c.main_osc_enable && c.main_pll_enable);
    return {hs, mo, pl, 1'b1, (m == MODE_SUB) || c.sub_osc_enable, 6'h00};
  endfunction
  // Raise one source, expect a wake or a quiet window
  task automatic try(bit r, int b, bit e);
    int i;
    if (e) wq.push_back(1'b1);
    if (r) lsrc_ready_i <= 1'b0;
    if (r) rst_src_i[b] <= 1'b1;
    else irq_src_i[b] <= 1'b1;
    for (i = 0; i < 20 && (!e || wq.size() > 0); i++) step(1);
    if (wq.size() > 0) begin
      fails++;
      wrap_up();
    end
    res_seen = 0;
    if (r) rst_src_i[b] <= 1'b0;
    else irq_src_i[b] <= 1'b0;
    step(4);
    if (e && r) begin
      `CHK(res_seen, 0)
      lsrc_ready_i <= 1'b1;
      for (i = 0; i < 20 && res_seen == 0; i++) step(1);
      `CHK(res_seen, 1)
      `CHK(resume_mode_o, MODE_HSRC)
    end else if (e) begin
      `CHK(resume_mode_o, mode)
    end
    lsrc_ready_i <= 1'b1;
    step(1);
  endtask
  initial begin
    clock_mode_control_t c;
    logic [2:0] m;
    void'($urandom(79));
    step(5);
    `CHK(clk_run_o, 11'h7ff)
    `CHK({wake_o, irq_o, rdata_o}, 18'h00000)
    arst_n_i <= 1'b1;
    step(1);
    bus(ADDR_MASK, 16'(MASK_RESET), 0);
    bus(4'hf, 16'h1234, 1);
    bus(4'hf, 16'h0000, 0);
    // Clock gating in the timer, RTC and stop standby states
    for (int k = 0; k < 12; k++) begin
      c = clock_mode_control_t'(7'($urandom));
      m = modes[k % 5];
      bus(ADDR_CTRL, {9'h000, c}, 1);
      bus(ADDR_CTRL, {9'h000, c}, 0);
      enter(k < 10 ? ST_TIMER : (k == 10 ? ST_RTC : ST_STOP), m);
      bus(ADDR_CLKS, {5'h00, exp_clk(stby_state_i, m, c)}, 0);
      try(0, SRC_NMI, 1);
    end
    // Wake qualification per state and source
    for (int s = 0; s < 4; s++) begin
      for (int b = 0; b < NSRC + NRST; b++) begin
        enter(stby_state_t'(4'h1 << s), modes[$urandom_range(4)]);
        if (b < NSRC) try(0, b, allowed(stby_state_i, mode, 0, b));
        else try(1, b - NSRC, allowed(stby_state_i, mode, 1, b - NSRC));
        if (wq.size() == 0 && dut.wake_o !== 1'b1 && stby_enter_i == 0)
          ;
        `CHK(32'(wq.size()), 0)
        if (!allowed(stby_state_i, mode, b >= NSRC, b % NSRC)) begin
          try(1, RST_PIN, 1);
        end
        bus(ADDR_STATUS, 16'h07ff, 1);
      end
    end
    // Masked sleep source, sticky status, level interrupt, clear
    bus(ADDR_MASK, 16'h07ff, 1);
    enter(ST_SLEEP, MODE_MAIN);
    try(0, SRC_PERIPH, 0);
    bus(ADDR_STATUS, 16'h0400, 0);
    `CHK(irq_o, 1'b0)
    bus(ADDR_MASK, 16'h0000, 1);
    step(2);
    `CHK(irq_o, 1'b1)
    bus(ADDR_STATUS, 16'h0400, 1);
    step(2);
    `CHK(irq_o, 1'b0)
    try(0, SRC_NMI, 1);
    step(5);
    wrap_up();
  end
endmodule
`undef CHK
`default_nettype wire
